//--- src/ieee_sr_top.sv
// status reporting register bank with APB slave and interrupt
`timescale 1ns/1ps
// Behaviour
// - clear-all command zeroes event status, generator status and request.
// - clear-all command leaves every enable register unchanged.
// - event enable set command loads the event enable register.
// - event status query returns whole register, then clears it.
// - event status query with index returns one bit, clears only it.
// - power-on clear flag set: clear status and enables at power-up.
// - power-on clear flag clear: enables keep stored values at power-up.
// - power-on clear command sets the flag from its parameter.
// - poll enable set command loads the serial poll enable register.
// - poll byte query returns whole byte or one indexed bit.
// - reading the serial poll byte never modifies it.
// - generator enable command loads the generator enable register.
// - generator status query returns and clears byte or one bit.
// - summary bits follow any enabled set bit of their source.
// - service request only on rising edge of an enabled poll bit.
// - event status bits stay set until read or clear-all.
module ieee_sr_top
  import ieee_sr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ieee_sr_pkg::IEEE_SR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] esr_event,
  input wire logic [7:0] gen_event,
  input wire logic [7:0] gen_level,
  input wire logic sweep_done,
  input wire logic mod_enabled,
  input wire logic user_srq,
  input wire logic out_queue_avail,
  input wire logic no_command,
  input wire ieee_sr_pkg::ieee_sr_nv_t nv_in,
  output ieee_sr_pkg::ieee_sr_nv_t nv_out,
  output logic srq_pulse,
  output logic irq
);
  import ieee_sr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {IEEE_SR_ST_INIT, IEEE_SR_ST_RUN} ieee_sr_state_t;

  ieee_sr_state_t state, next_state;
  logic [7:0] esr, next_esr;
  logic [7:0] ese, next_ese;
  logic [7:0] gsr, next_gsr;
  logic [7:0] gse, next_gse;
  logic [7:0] sre, next_sre;
  logic psc, next_psc;
  logic rqs, next_rqs;
  logic [7:0] result, next_result;
  logic [7:0] spb_req_prev, next_spb_req_prev;
  logic [IEEE_SR_IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [IEEE_SR_IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic next_srq_pulse;

  logic [7:0] spb;
  logic [7:0] spb_req;
  logic [7:0] rise;
  logic srq_event;
  logic done_event;
  logic setup, wr_acc, rd_setup, mapped;
  ieee_sr_cmd_t cmd;
  logic [7:0] bit_mask;

  // ----------------------------------------------------------------
  // serial poll byte
  // ----------------------------------------------------------------
  // summary bits are combinational so they track their sources
  // without any latency
  always_comb
  begin
    spb = IEEE_SR_BYTE_ZERO;
    spb[IEEE_SR_SPB_SWEEP] = sweep_done;
    spb[IEEE_SR_SPB_MOD] = mod_enabled;
    spb[IEEE_SR_SPB_USER] = user_srq;
    spb[IEEE_SR_SPB_GEN] = |(gsr & gse);
    spb[IEEE_SR_SPB_MAV] = out_queue_avail;
    spb[IEEE_SR_SPB_ESB] = |(esr & ese);
    spb[IEEE_SR_SPB_RQS] = rqs;
    spb[IEEE_SR_SPB_NOCMD] = no_command;
  end

  // the request bit itself never feeds its own edge detector
  always_comb
  begin
    spb_req = spb & sre;
    spb_req[IEEE_SR_SPB_RQS] = 1'b0;
  end

  // one request per setting of an enabled bit
  assign rise = spb_req & ~spb_req_prev;
  assign srq_event = (state == IEEE_SR_ST_RUN) && (|rise);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign rd_setup = setup && !pwrite;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr == IEEE_SR_OFS_CMD)
               || (paddr == IEEE_SR_OFS_RESULT)
               || (paddr == IEEE_SR_OFS_STB)
               || (paddr == IEEE_SR_OFS_IRQ_STAT)
               || (paddr == IEEE_SR_OFS_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    cmd = '0;
    cmd.op = pwdata[IEEE_SR_OP_LSB +: IEEE_SR_OP_W];
    cmd.has_index = pwdata[IEEE_SR_HASIDX_BIT];
    cmd.index = pwdata[IEEE_SR_IDX_LSB +: 3];
    cmd.value = pwdata[IEEE_SR_VAL_LSB +: 8];
    if (!(wr_acc && paddr == IEEE_SR_OFS_CMD))
    begin
      cmd.op = IEEE_SR_OP_NOP;
    end
  end

  assign bit_mask = 8'h01 << cmd.index;
  assign done_event = (cmd.op != IEEE_SR_OP_NOP)
                   && (state == IEEE_SR_ST_RUN);

  // ----------------------------------------------------------------
  // command execution and status update
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_esr = esr;
    next_ese = ese;
    next_gsr = gsr;
    next_gse = gse;
    next_sre = sre;
    next_psc = psc;
    next_rqs = rqs;
    next_result = result;
    next_spb_req_prev = spb_req;
    case (state)
      IEEE_SR_ST_INIT:
      begin
        // strap values are taken one edge after reset release
        next_psc = nv_in.psc;
        next_esr = IEEE_SR_BYTE_ZERO;
        next_gsr = IEEE_SR_BYTE_ZERO;
        next_esr[IEEE_SR_ESR_PON] = 1'b1;
        if (nv_in.psc)
        begin
          next_ese = IEEE_SR_BYTE_ZERO;
          next_sre = IEEE_SR_BYTE_ZERO;
          next_gse = IEEE_SR_BYTE_ZERO;
        end
        else
        begin
          next_ese = nv_in.ese;
          next_sre = nv_in.sre;
          next_gse = nv_in.gse;
        end
        // zero history lets an enabled bit raise a request at power-up
        next_spb_req_prev = IEEE_SR_BYTE_ZERO;
        next_state = IEEE_SR_ST_RUN;
      end
      IEEE_SR_ST_RUN:
      begin
        case (cmd.op)
          IEEE_SR_OP_CLS:
          begin
            // enables are left alone on purpose
            next_esr = IEEE_SR_BYTE_ZERO;
            next_gsr = IEEE_SR_BYTE_ZERO;
            next_rqs = 1'b0;
          end
          IEEE_SR_OP_ESE_SET: next_ese = cmd.value;
          IEEE_SR_OP_ESE_QRY: next_result = ese;
          IEEE_SR_OP_ESR_QRY:
          begin
            // result takes the old value in the same edge as the clear
            if (cmd.has_index)
            begin
              next_result = {7'h00, esr[cmd.index]};
              next_esr = esr & ~bit_mask;
            end
            else
            begin
              next_result = esr;
              next_esr = IEEE_SR_BYTE_ZERO;
            end
          end
          IEEE_SR_OP_PSC_SET: next_psc = cmd.value != 8'h00;
          IEEE_SR_OP_PSC_QRY: next_result = {7'h00, psc};
          IEEE_SR_OP_SRE_SET: next_sre = cmd.value;
          IEEE_SR_OP_SRE_QRY: next_result = sre;
          IEEE_SR_OP_STB_QRY:
          begin
            // no state change: the poll byte is only a summary
            if (cmd.has_index)
            begin
              next_result = {7'h00, spb[cmd.index]};
            end
            else
            begin
              next_result = spb;
            end
          end
          IEEE_SR_OP_GSE_SET: next_gse = cmd.value;
          IEEE_SR_OP_GSE_QRY: next_result = gse;
          IEEE_SR_OP_GSR_QRY:
          begin
            if (cmd.has_index)
            begin
              next_result = {7'h00, gsr[cmd.index]};
              next_gsr = gsr & ~bit_mask;
            end
            else
            begin
              next_result = gsr;
              next_gsr = IEEE_SR_BYTE_ZERO;
            end
          end
          default:
          begin
          end
        endcase
        // new events win over any clear in the same cycle
        next_esr = next_esr | esr_event;
        next_gsr = next_gsr | gen_event | gen_level;
        if (srq_event)
        begin
          next_rqs = 1'b1;
        end
      end
      default: next_state = IEEE_SR_ST_INIT;
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt and read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_acc && paddr == IEEE_SR_OFS_IRQ_MASK)
    begin
      next_irq_mask = pwdata[IEEE_SR_IRQ_W-1:0];
    end
    if (wr_acc && paddr == IEEE_SR_OFS_IRQ_STAT)
    begin
      next_irq_stat = irq_stat & ~pwdata[IEEE_SR_IRQ_W-1:0];
    end
    next_irq_stat[IEEE_SR_IRQ_SRQ] = next_irq_stat[IEEE_SR_IRQ_SRQ]
                                  | srq_event;
    next_irq_stat[IEEE_SR_IRQ_DONE] = next_irq_stat[IEEE_SR_IRQ_DONE]
                                   | done_event;
    next_srq_pulse = srq_event;
    // read data is latched in setup so it comes from a flop
    next_prdata = prdata;
    if (rd_setup)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        IEEE_SR_OFS_RESULT: next_prdata[7:0] = result;
        IEEE_SR_OFS_STB: next_prdata[7:0] = spb;
        IEEE_SR_OFS_IRQ_STAT: next_prdata[IEEE_SR_IRQ_W-1:0] = irq_stat;
        IEEE_SR_OFS_IRQ_MASK: next_prdata[IEEE_SR_IRQ_W-1:0] = irq_mask;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= IEEE_SR_ST_INIT;
      esr <= IEEE_SR_BYTE_ZERO;
      ese <= IEEE_SR_BYTE_ZERO;
      gsr <= IEEE_SR_BYTE_ZERO;
      gse <= IEEE_SR_BYTE_ZERO;
      sre <= IEEE_SR_BYTE_ZERO;
      psc <= 1'b0;
      rqs <= 1'b0;
      result <= IEEE_SR_BYTE_ZERO;
      spb_req_prev <= IEEE_SR_BYTE_ZERO;
      irq_stat <= '0;
      irq_mask <= '0;
      prdata <= 32'h0000_0000;
      srq_pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      esr <= next_esr;
      ese <= next_ese;
      gsr <= next_gsr;
      gse <= next_gse;
      sre <= next_sre;
      psc <= next_psc;
      rqs <= next_rqs;
      result <= next_result;
      spb_req_prev <= next_spb_req_prev;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      srq_pulse <= next_srq_pulse;
    end
  end

  // outside storage follows the live settings for the next power cycle
  assign nv_out = '{psc: psc, ese: ese, sre: sre, gse: gse};
  assign irq = |(irq_stat & irq_mask);

endmodule // ieee_sr_top

//--- src/ieee_sr_pkg.sv
// package for the status reporting block: offsets, fields, commands, types
package ieee_sr_pkg;
  // ----------------------------------------------------------------
  // bus register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] IEEE_SR_OFS_CMD = 8'h00;
  localparam logic [7:0] IEEE_SR_OFS_RESULT = 8'h04;
  localparam logic [7:0] IEEE_SR_OFS_STB = 8'h08;
  localparam logic [7:0] IEEE_SR_OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] IEEE_SR_OFS_IRQ_MASK = 8'h10;
  localparam int IEEE_SR_ADDR_W = 8;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int IEEE_SR_OP_LSB = 0;
  localparam int IEEE_SR_OP_W = 4;
  localparam int IEEE_SR_HASIDX_BIT = 4;
  localparam int IEEE_SR_IDX_LSB = 5;
  localparam int IEEE_SR_VAL_LSB = 8;

  // ----------------------------------------------------------------
  // serial poll byte bit positions, plus the power-on bit of the event status register
  // ----------------------------------------------------------------
  localparam int IEEE_SR_SPB_SWEEP = 0;
  localparam int IEEE_SR_SPB_MOD = 1;
  localparam int IEEE_SR_SPB_USER = 2;
  localparam int IEEE_SR_SPB_GEN = 3;
  localparam int IEEE_SR_SPB_MAV = 4;
  localparam int IEEE_SR_SPB_ESB = 5;
  localparam int IEEE_SR_SPB_RQS = 6;
  localparam int IEEE_SR_SPB_NOCMD = 7;
  localparam int IEEE_SR_ESR_PON = 7;

  // interrupt status bits
  localparam int IEEE_SR_IRQ_SRQ = 0;
  localparam int IEEE_SR_IRQ_DONE = 1;
  localparam int IEEE_SR_IRQ_W = 2;

  localparam logic [7:0] IEEE_SR_BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    IEEE_SR_OP_NOP = 4'h0,
    IEEE_SR_OP_CLS = 4'h1,
    IEEE_SR_OP_ESE_SET = 4'h2,
    IEEE_SR_OP_ESE_QRY = 4'h3,
    IEEE_SR_OP_ESR_QRY = 4'h4,
    IEEE_SR_OP_PSC_SET = 4'h5,
    IEEE_SR_OP_PSC_QRY = 4'h6,
    IEEE_SR_OP_SRE_SET = 4'h7,
    IEEE_SR_OP_SRE_QRY = 4'h8,
    IEEE_SR_OP_STB_QRY = 4'h9,
    IEEE_SR_OP_GSE_SET = 4'hA,
    IEEE_SR_OP_GSE_QRY = 4'hB,
    IEEE_SR_OP_GSR_QRY = 4'hC
  } ieee_sr_op_t;

  // one decoded common command
  typedef struct packed {
    logic [7:0] value;
    logic [2:0] index;
    logic has_index;
    logic [3:0] op;
  } ieee_sr_cmd_t;

  // values held in non-volatile storage outside the block
  typedef struct packed {
    logic psc;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] gse;
  } ieee_sr_nv_t;
endpackage

//--- sim/ieee_sr_props.sv
// assertion checker for the status reporting bank
`timescale 1ns/1ps
module ieee_sr_props
  import ieee_sr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ieee_sr_pkg::IEEE_SR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic srq_pulse,
  input wire logic irq,
  input wire ieee_sr_pkg::ieee_sr_nv_t nv_out
);
  logic mapped;
  logic cmd_wr;
  logic [3:0] op;
  logic [7:0] val;
  assign mapped = paddr inside {IEEE_SR_OFS_CMD, IEEE_SR_OFS_RESULT,
    IEEE_SR_OFS_STB, IEEE_SR_OFS_IRQ_STAT, IEEE_SR_OFS_IRQ_MASK};
  assign cmd_wr = psel && penable && pwrite && paddr == IEEE_SR_OFS_CMD;
  assign op = pwdata[3:0];
  assign val = pwdata[15:8];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_pready_high: assert property (pready) else $error("pready low");
  a_slverr_map: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr wrong");
  a_unmapped_zero: assert property (psel && penable && !pwrite && !mapped
    |-> prdata == 32'h00000000) else $error("unmapped read not zero");
  a_cls_keep: assert property (cmd_wr && op == IEEE_SR_OP_CLS
    |=> $stable(nv_out)) else $error("clear-all touched enables");
  a_ese_load: assert property (cmd_wr && op == IEEE_SR_OP_ESE_SET
    |=> nv_out.ese == $past(val)) else $error("event enable not loaded");
  a_sre_load: assert property (cmd_wr && op == IEEE_SR_OP_SRE_SET
    |=> nv_out.sre == $past(val)) else $error("poll enable not loaded");
  a_gse_load: assert property (cmd_wr && op == IEEE_SR_OP_GSE_SET
    |=> nv_out.gse == $past(val)) else $error("gen enable not loaded");
  a_psc_load: assert property (cmd_wr && op == IEEE_SR_OP_PSC_SET
    |=> nv_out.psc == ($past(val) != 8'h00)) else $error("psc not loaded");
  a_query_keep: assert property (cmd_wr
    && op inside {IEEE_SR_OP_ESE_QRY, IEEE_SR_OP_PSC_QRY,
    IEEE_SR_OP_SRE_QRY, IEEE_SR_OP_GSE_QRY}
    |=> $stable(nv_out)) else $error("query changed stored value");
  c_srq: cover property (srq_pulse);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule // ieee_sr_props

bind ieee_sr_top ieee_sr_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .srq_pulse, .irq,
  .nv_out);

//--- sim/ieee_sr_host.sv
// apb host model that issues commands to the status bank
`timescale 1ns/1ps
module ieee_sr_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must never pass for a fresh write
    pwdata <= ~d;
  endtask
endmodule // ieee_sr_host

//--- sim/tb_top.sv
// self-checking bench for the status reporting bank
`timescale 1ns/1ps
module tb_top;
  import ieee_sr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, srq_pulse, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] esr_event = 8'h00;
  logic [7:0] gen_event = 8'h00;
  logic sweep_done = 1'b0;
  logic [7:0] gen_level = 8'h00;
  logic mod_enabled = 1'b0;
  logic user_srq = 1'b0;
  logic out_queue_avail = 1'b0;
  logic e;
  ieee_sr_nv_t nv_in = 25'h0802000;
  ieee_sr_nv_t nv_out;
  int n_errors = 0;
  int checks_done = 0;
  int srq_n = 0;
  logic [24:0] rows [17] = '{25'h1_01_00F4, 25'h1_34_0004, 25'h1_00_0004,
    25'h1_01_001C, 25'h1_08_000C, 25'h1_00_000C, 25'h0_00_5A02,
    25'h1_5A_0003, 25'h0_00_A107, 25'h1_A1_0008, 25'h0_00_0F0A,
    25'h1_0F_000B, 25'h0_00_0205, 25'h1_01_0006, 25'h1_C1_0009,
    25'h1_01_00D9, 25'h1_C1_0009};
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (srq_pulse === 1'b1) srq_n <= srq_n + 1;
  ieee_sr_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  ieee_sr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .esr_event, .gen_event,
    .gen_level, .sweep_done, .mod_enabled, .user_srq, .out_queue_avail,
    .no_command(1'b1), .nv_in, .nv_out, .srq_pulse,
    .irq);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      $display("mismatch %s expected %h seen %h", n, x, s);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic f;
    host.xfer(1'b1, a, d, r, f);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic f;
    host.xfer(1'b0, a, 32'h00000000, r, f);
  endtask
  task automatic run(input logic [24:0] r);
    logic [31:0] v;
    wr(IEEE_SR_OFS_CMD, {16'h0000, r[15:0]});
    if (r[24])
    begin
      rd(IEEE_SR_OFS_RESULT, v);
      chk("result", v, {24'h000000, r[23:16]});
    end
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge pclk);
    esr_event <= v;
    @(posedge pclk);
    esr_event <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hang well past the fewer than two hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("nv_out", 32'(nv_out), 32'h0802000);
    rd(IEEE_SR_OFS_STB, q);
    chk("stb", q, 32'hE0);
    wr(IEEE_SR_OFS_IRQ_MASK, 32'h1);
    rd(IEEE_SR_OFS_IRQ_STAT, q);
    chk("irq_stat", q, 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(IEEE_SR_OFS_IRQ_STAT, 32'h1);
    sweep_done <= 1'b1;
    gen_event <= 8'h09;
    @(negedge pclk);
    chk("irq", 32'(irq), 32'h0);
    @(posedge pclk);
    gen_event <= 8'h00;
    pulse(8'h34);
    foreach (rows[i]) run(rows[i]);
    chk("srq_n", srq_n, 2);
    // every executed command leaves its done flag beside the request flag
    rd(IEEE_SR_OFS_IRQ_STAT, q);
    chk("irq_stat", q, 32'h3);
    host.xfer(1'b0, 8'h14, 32'h00000000, q, e);
    chk("slverr", 32'(e), 32'h1);
    chk("unmapped", q, 32'h0);
    @(posedge pclk);
    gen_event <= 8'h40;
    gen_level <= 8'h04;
    @(posedge pclk);
    gen_event <= 8'h00;
    gen_level <= 8'h00;
    pulse(8'h04);
    // only the level bit is enabled, so the generator summary rises
    rd(IEEE_SR_OFS_STB, q);
    chk("stb", q, 32'hC9);
    run(25'h0_00_0001);
    run(25'h1_00_0004);
    run(25'h1_00_000C);
    rd(IEEE_SR_OFS_STB, q);
    chk("stb", q, 32'h81);
    chk("nv_out", 32'(nv_out), 32'h15AA10F);
    pulse(8'h10);
    pulse(8'h10);
    rd(IEEE_SR_OFS_STB, q);
    chk("stb", q, 32'hE1);
    chk("srq_n", srq_n, 3);
    chk("irq", 32'(irq), 32'h1);
    mod_enabled <= 1'b1;
    user_srq <= 1'b1;
    out_queue_avail <= 1'b1;
    rd(IEEE_SR_OFS_STB, q);
    chk("stb", q, 32'hF7);
    chk("srq_n", srq_n, 3);
    presetn <= 1'b0;
    nv_in <= 25'h1FFFFFF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("nv_out", 32'(nv_out), 32'h1000000);
    rd(IEEE_SR_OFS_STB, q);
    chk("stb", q, 32'h97);
    print_verdict;
  end
endmodule // tb_top
